/* rtl/glue_pkg.sv */
// Package with the address map, decode constants, register offsets and bus phase type of the glue logic.
`default_nettype none
package glue_pkg;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [7:0]  ROM_HIGH_BASE    = 8'h00;
    localparam logic [7:0]  ROM_HIGH_LIMIT   = 8'h7F;
    localparam logic [7:0]  RAM_HIGH_BASE    = 8'h80;
    localparam logic [7:0]  RAM_HIGH_LIMIT   = 8'h9F;
    localparam logic [7:0]  PORT_A_IO_BASE   = 8'h00;
    localparam logic [7:0]  PORT_A_IO_LIMIT  = 8'h0F;
    localparam logic [7:0]  PORT_B_IO_BASE   = 8'h10;
    localparam logic [7:0]  PORT_B_IO_LIMIT  = 8'h1F;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          BYTE_W           = 8;
    localparam int          PORT_A_C_W       = 6;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [5:0]  SIX_RESET        = 6'h00;
    localparam logic [1:0]  SEL_NONE         = 2'h0;
    // ------------------------------------------------------------
    // Port unit register offsets within an I/O range
    // ------------------------------------------------------------
    localparam logic [1:0]  PORT_OFS_0       = 2'h0;
    localparam logic [1:0]  PORT_OFS_1       = 2'h1;
    localparam logic [1:0]  PORT_OFS_2       = 2'h2;
    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_ADDRESS = 2'b01,
        BUS_DATA    = 2'b11
    } bus_phase_t;
endpackage : glue_pkg
`default_nettype wire

/* rtl/port_unit.sv */
// Parallel port unit: one output register written and input ports read over I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module port_unit
    import glue_pkg::*;
#(
    parameter int OUT_W = 8
)(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             select_in,
    input  wire logic             write_in,
    input  wire logic             read_in,
    input  wire logic [1:0]       offset_in,
    input  wire logic [7:0]       wdata_in,
    input  wire logic [7:0]       in0_in,
    input  wire logic [7:0]       in1_in,
    input  wire logic [7:0]       out0_rd_in,
    output logic      [OUT_W-1:0] out_port_out,
    output logic      [7:0]       rdata_out
);
    // ------------------------------------------------------------
    // Output port and read mux
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            out_port_out <= '0;
        else if (select_in && write_in && offset_in == PORT_OFS_2)
            out_port_out <= wdata_in[OUT_W-1:0];
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= BYTE_RESET;
        else if (select_in && read_in)
        begin
            if (offset_in == PORT_OFS_0)
                rdata_out <= in0_in;
            else if (offset_in == PORT_OFS_1)
                rdata_out <= in1_in;
            else
                rdata_out <= out0_rd_in;
        end
    end
endmodule : port_unit
`default_nettype wire

/* rtl/cpu_bus_address_decode_glue.sv */
// Address latch, chip select decoder, strobe routing and parallel port units for an 8-bit CPU bus.
// Operation
// - ROM and RAM enables decode high address with memory qualifier and strobes.
// - Read strobe drives ROM output enable directly, not via decoder.
// - Read and write strobes go directly to RAM controls.
// - Low address byte captured from shared bus by high-active latch strobe.
// - Latch transparent while strobe high, output follows bus.
// - Strobe fall holds latched byte until strobe rises again.
// - Port unit A has 8-bit input, 8-bit output, 6-bit output.
// - Port unit B has two 8-bit inputs, one 8-bit output.
// - Separate select for each port unit.
// - Port unit selects only in I/O space.
// - Data and low address share a bus; high address separate.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_address_decode_glue
    import glue_pkg::*;
#(
    parameter logic [7:0] ROM_BASE  = ROM_HIGH_BASE,
    parameter logic [7:0] ROM_LIMIT = ROM_HIGH_LIMIT,
    parameter logic [7:0] RAM_BASE  = RAM_HIGH_BASE,
    parameter logic [7:0] RAM_LIMIT = RAM_HIGH_LIMIT
)(
    input  wire logic       CLOCK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic [7:0] AD_IN,
    input  wire logic [7:0] ADDR_HIGH_IN,
    input  wire logic       ALE_IN,
    input  wire logic       RD_N_IN,
    input  wire logic       WR_N_IN,
    input  wire logic       IO_M_IN,
    input  wire logic [7:0] PORT_A_IN_IN,
    input  wire logic [7:0] PORT_B_IN0_IN,
    input  wire logic [7:0] PORT_B_IN1_IN,
    output logic [7:0]      AD_OUT,
    output logic            AD_OE_N_OUT,
    output logic [7:0]      LOW_ADDR_OUT,
    output logic            ROM_CE_N_OUT,
    output logic            ROM_OE_N_OUT,
    output logic            RAM_CE_N_OUT,
    output logic            RAM_RD_N_OUT,
    output logic            RAM_WR_N_OUT,
    output logic            PORT_UNIT_A_SELECT_N_OUT,
    output logic            PORT_UNIT_B_SELECT_N_OUT,
    output logic [7:0]      PORT_A_OUT0_OUT,
    output logic [5:0]      PORT_A_OUT1_OUT,
    output logic [7:0]      PORT_B_OUT_OUT
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Pins are asynchronous; every bus input passes two stages, so the
    // decoded outputs trail the pins by three cycles of the 40 MHz clock.
    logic [27:0] sync1;
    logic [27:0] sync2;
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= {16'h0000, 4'h6, 8'h00};
            sync2 <= {16'h0000, 4'h6, 8'h00};
        end
        else
        begin
            sync1 <= {AD_IN, ADDR_HIGH_IN, ALE_IN, RD_N_IN, WR_N_IN, IO_M_IN, PORT_A_IN_IN};
            sync2 <= sync1;
        end
    end
    logic [7:0] ad;
    logic [7:0] ahigh;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       io_m;
    logic [7:0] pa_in;
    assign {ad, ahigh, ale, rd_n, wr_n, io_m, pa_in} = sync2;

    logic [15:0] b_sync1;
    logic [15:0] b_sync2;
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            b_sync1 <= 16'h0000;
            b_sync2 <= 16'h0000;
        end
        else
        begin
            b_sync1 <= {PORT_B_IN0_IN, PORT_B_IN1_IN};
            b_sync2 <= b_sync1;
        end
    end

    // ------------------------------------------------------------
    // Low address latch
    // ------------------------------------------------------------
    // The latch follows the shared bus while the strobe is high and keeps
    // the last sampled byte once it falls, so data on the bus is ignored.
    logic [7:0] low_addr;
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
            low_addr <= BYTE_RESET;
        else if (ale)
            low_addr <= ad;
    end
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
            LOW_ADDR_OUT <= BYTE_RESET;
        else if (ale)
            LOW_ADDR_OUT <= ad;
    end

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    logic rd;
    logic wr;
    logic rom_hit;
    logic ram_hit;
    logic pa_hit;
    logic pb_hit;
    assign rd      = !rd_n && !ale;
    assign wr      = !wr_n && !ale;
    assign rom_hit = !io_m && (rd || wr) && ahigh >= ROM_BASE && ahigh <= ROM_LIMIT;
    assign ram_hit = !io_m && (rd || wr) && !rom_hit && ahigh >= RAM_BASE && ahigh <= RAM_LIMIT;
    assign pa_hit  = io_m && (rd || wr) && low_addr >= PORT_A_IO_BASE && low_addr <= PORT_A_IO_LIMIT;
    assign pb_hit  = io_m && (rd || wr) && !pa_hit && low_addr >= PORT_B_IO_BASE
                     && low_addr <= PORT_B_IO_LIMIT;

    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ROM_CE_N_OUT             <= 1'b1;
            RAM_CE_N_OUT             <= 1'b1;
            PORT_UNIT_A_SELECT_N_OUT <= 1'b1;
            PORT_UNIT_B_SELECT_N_OUT <= 1'b1;
        end
        else
        begin
            ROM_CE_N_OUT             <= !rom_hit;
            RAM_CE_N_OUT             <= !ram_hit;
            PORT_UNIT_A_SELECT_N_OUT <= !pa_hit;
            PORT_UNIT_B_SELECT_N_OUT <= !pb_hit;
        end
    end

    // Strobes bypass the decoder and only pass the synchronisers and an output register.
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ROM_OE_N_OUT <= 1'b1;
            RAM_RD_N_OUT <= 1'b1;
            RAM_WR_N_OUT <= 1'b1;
        end
        else
        begin
            ROM_OE_N_OUT <= rd_n;
            RAM_RD_N_OUT <= rd_n;
            RAM_WR_N_OUT <= wr_n;
        end
    end

    // ------------------------------------------------------------
    // Port units
    // ------------------------------------------------------------
    logic       wr_edge;
    logic       wr_n_q;
    logic [7:0] pa_rdata;
    logic [7:0] pb_rdata;
    logic [7:0] pa_out6_rd;
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
            wr_n_q <= 1'b1;
        else
            wr_n_q <= wr_n;
    end
    // Writes take the data on the rising edge of the write strobe.
    assign wr_edge = wr_n && !wr_n_q && !ale;
    assign pa_out6_rd = {2'h0, PORT_A_OUT1_OUT};

    port_unit #(.OUT_W(BYTE_W)) u_port_a0 (
        .clk_in       (CLOCK_IN),
        .rst_n_in     (rst_n),
        .select_in    (io_m && low_addr >= PORT_A_IO_BASE && low_addr <= PORT_A_IO_LIMIT),
        .write_in     (wr_edge),
        .read_in      (rd),
        .offset_in    (low_addr[1:0]),
        .wdata_in     (ad),
        .in0_in       (pa_in),
        .in1_in       (pa_out6_rd),
        .out0_rd_in   (PORT_A_OUT0_OUT),
        .out_port_out (PORT_A_OUT0_OUT),
        .rdata_out    (pa_rdata)
    );

    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
            PORT_A_OUT1_OUT <= SIX_RESET;
        else if (wr_edge && io_m && low_addr >= PORT_A_IO_BASE && low_addr <= PORT_A_IO_LIMIT
                 && low_addr[1:0] == PORT_OFS_1)
            PORT_A_OUT1_OUT <= ad[PORT_A_C_W-1:0];
    end

    port_unit #(.OUT_W(BYTE_W)) u_port_b (
        .clk_in       (CLOCK_IN),
        .rst_n_in     (rst_n),
        .select_in    (io_m && low_addr >= PORT_B_IO_BASE && low_addr <= PORT_B_IO_LIMIT),
        .write_in     (wr_edge),
        .read_in      (rd),
        .offset_in    (low_addr[1:0]),
        .wdata_in     (ad),
        .in0_in       (b_sync2[15:8]),
        .in1_in       (b_sync2[7:0]),
        .out0_rd_in   (PORT_B_OUT_OUT),
        .out_port_out (PORT_B_OUT_OUT),
        .rdata_out    (pb_rdata)
    );

    // ------------------------------------------------------------
    // Read data back onto the shared bus
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            AD_OUT      <= BYTE_RESET;
            AD_OE_N_OUT <= 1'b1;
        end
        else
        begin
            AD_OUT      <= PORT_UNIT_A_SELECT_N_OUT ? pb_rdata : pa_rdata;
            AD_OE_N_OUT <= !(io_m && rd && (pa_hit || pb_hit));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_onehot_selects: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        $countones({~ROM_CE_N_OUT, ~RAM_CE_N_OUT, ~PORT_UNIT_A_SELECT_N_OUT, ~PORT_UNIT_B_SELECT_N_OUT}) <= 1)
        else $error("More than one chip select active.");
    a_idle_no_select: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        (rd_n && wr_n) |=> (ROM_CE_N_OUT && RAM_CE_N_OUT && PORT_UNIT_A_SELECT_N_OUT && PORT_UNIT_B_SELECT_N_OUT))
        else $error("Select active with no strobe.");
    a_rom_oe_direct: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        ##1 ROM_OE_N_OUT == $past(rd_n))
        else $error("ROM output enable does not follow read.");
    a_ram_strobes: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        ##1 (RAM_RD_N_OUT == $past(rd_n) && RAM_WR_N_OUT == $past(wr_n)))
        else $error("RAM strobes do not follow processor.");
    a_latch_follow: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        ale |=> LOW_ADDR_OUT == $past(ad))
        else $error("Latch not transparent.");
    a_latch_hold: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        (!ale [*2]) |-> $stable(LOW_ADDR_OUT))
        else $error("Latch changed while strobe low.");
    a_rom_decode: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        (!io_m && !rd_n && !ale && ahigh <= ROM_LIMIT && ahigh >= ROM_BASE) |=> !ROM_CE_N_OUT)
        else $error("ROM not selected.");
    a_ports_io_only: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        !io_m |=> (PORT_UNIT_A_SELECT_N_OUT && PORT_UNIT_B_SELECT_N_OUT))
        else $error("Port select in memory cycle.");
    a_ram_decode: assert property (@(posedge CLOCK_IN) disable iff (!rst_n)
        (!io_m && !wr_n && !ale && !rom_hit && ahigh >= RAM_BASE && ahigh <= RAM_LIMIT) |=> !RAM_CE_N_OUT)
        else $error("RAM not selected.");
    c_rom_read: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) !ROM_CE_N_OUT && !ROM_OE_N_OUT);
    c_ram_write: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) !RAM_CE_N_OUT && !RAM_WR_N_OUT);
    c_port_a: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) !PORT_UNIT_A_SELECT_N_OUT);
    c_port_b: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) !PORT_UNIT_B_SELECT_N_OUT);
endmodule : cpu_bus_address_decode_glue
`default_nettype wire

/* bench/cpu_model.sv */
// Processor bus model that runs multiplexed memory and I/O cycles.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] ad_in,
    input  wire logic [6:0] sel_in,
    output logic      [7:0] ad_out,
    output logic      [7:0] hi_out,
    output logic            ale_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic            io_m_out
);
    logic [6:0] snap;
    initial
    begin
        ad_out   = 8'h00;
        hi_out   = 8'h00;
        ale_out  = 1'b0;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        io_m_out = 1'b0;
    end
    task automatic put_addr(input logic io, input logic [7:0] h, input logic [7:0] l);
        @(posedge clk_in);
        io_m_out <= io;
        hi_out   <= h;
        ad_out   <= l;
        ale_out  <= 1'b1;
    endtask : put_addr
    // A released bus shows the inverse of its last value, so a stale address can never pass.
    task automatic end_addr();
        @(posedge clk_in);
        ale_out <= 1'b0;
        @(posedge clk_in);
        ad_out <= ~ad_out;
    endtask : end_addr
    task automatic cycle(input logic io, input logic [7:0] h, input logic [7:0] l, input logic w,
                         input logic [7:0] d, output logic [7:0] r);
        put_addr(io, h, l);
        repeat (3) @(posedge clk_in);
        end_addr();
        @(posedge clk_in);
        if (w)
            ad_out <= d;
        repeat (3) @(posedge clk_in);
        if (w)
            wr_n_out <= 1'b0;
        else
            rd_n_out <= 1'b0;
        repeat (7) @(posedge clk_in);
        snap = sel_in;
        r = ad_in;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        ad_out <= ~ad_out;
        repeat (3) @(posedge clk_in);
    endtask : cycle
endmodule : cpu_model
`default_nettype wire

/* bench/test_cpu_bus_address_decode_glue.sv */
// Self-checking testbench for the CPU bus glue logic.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_bus_address_decode_glue;
    import glue_pkg::*;
    logic       clk, rst_n;
    logic [7:0] pa_in, pb0_in, pb1_in, cpu_ad, hi, ad_out, low_addr, pa_out0, pb_out;
    logic [5:0] pa_out1;
    logic       ale, rd_n, wr_n, io_m, ad_oe_n;
    logic       rom_ce_n, rom_oe_n, ram_ce_n, ram_rd_n, ram_wr_n, a_sel_n, b_sel_n;
    int         errors, check_count;
    wire logic [6:0] sel = {rom_ce_n, rom_oe_n, ram_ce_n, ram_rd_n, ram_wr_n, a_sel_n, b_sel_n};
    // The glue drives the shared bus only when its enable is low.
    wire logic [7:0] ad_bus = !ad_oe_n ? ad_out : cpu_ad;
    cpu_bus_address_decode_glue cpu_bus_address_decode_glue_inst (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .AD_IN(ad_bus), .ADDR_HIGH_IN(hi), .ALE_IN(ale),
        .RD_N_IN(rd_n), .WR_N_IN(wr_n), .IO_M_IN(io_m), .PORT_A_IN_IN(pa_in),
        .PORT_B_IN0_IN(pb0_in), .PORT_B_IN1_IN(pb1_in), .AD_OUT(ad_out), .AD_OE_N_OUT(ad_oe_n),
        .LOW_ADDR_OUT(low_addr), .ROM_CE_N_OUT(rom_ce_n), .ROM_OE_N_OUT(rom_oe_n),
        .RAM_CE_N_OUT(ram_ce_n), .RAM_RD_N_OUT(ram_rd_n), .RAM_WR_N_OUT(ram_wr_n),
        .PORT_UNIT_A_SELECT_N_OUT(a_sel_n), .PORT_UNIT_B_SELECT_N_OUT(b_sel_n),
        .PORT_A_OUT0_OUT(pa_out0), .PORT_A_OUT1_OUT(pa_out1), .PORT_B_OUT_OUT(pb_out));
    cpu_model cpu_model_inst (
        .clk_in(clk), .ad_in(ad_bus), .sel_in(sel), .ad_out(cpu_ad), .hi_out(hi),
        .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n), .io_m_out(io_m));
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check_sel(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_sel
    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_data
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    function automatic logic [6:0] exp_sel(input logic io, input logic [7:0] h, input logic [7:0] l,
                                            input logic w);
        logic rom, ram, pa, pb;
        rom = !io && h >= ROM_HIGH_BASE && h <= ROM_HIGH_LIMIT;
        ram = !io && h >= RAM_HIGH_BASE && h <= RAM_HIGH_LIMIT;
        pa = io && l >= PORT_A_IO_BASE && l <= PORT_A_IO_LIMIT;
        pb = io && l >= PORT_B_IO_BASE && l <= PORT_B_IO_LIMIT;
        return ~{rom, !w, ram, !w, w, pa, pb};
    endfunction : exp_sel
    task automatic run(input logic io, input logic [7:0] h, input logic [7:0] l, input logic w,
                       input logic [7:0] d, output logic [7:0] r);
        cpu_model_inst.cycle(io, h, l, w, d, r);
        check_sel(cpu_model_inst.snap, exp_sel(io, h, l, w));
        check_sel(sel, 7'h7F);
    endtask : run
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_mem();
        logic [7:0] his [5] = '{8'h00, 8'h7F, 8'h80, 8'h9F, 8'hA0};
        logic [7:0] r;
        for (int i = 0; i < 5; i++)
            run(1'b0, his[i], 8'h05, i == 2, 8'h5A, r);
        $display("t_mem done");
    endtask : t_mem
    task automatic t_io();
        logic [7:0] los [5] = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'h20};
        logic [7:0] r;
        for (int i = 0; i < 5; i++)
            run(1'b1, 8'h00, los[i], 1'b0, 8'h00, r);
        run(1'b0, 8'hC0, 8'h00, 1'b0, 8'h00, r);
        $display("t_io done");
    endtask : t_io
    task automatic t_latch();
        cpu_model_inst.put_addr(1'b0, 8'hC0, 8'h3C);
        repeat (4) @(posedge clk);
        check_data(low_addr, 8'h3C);
        cpu_model_inst.put_addr(1'b0, 8'hC0, 8'hA5);
        repeat (4) @(posedge clk);
        check_data(low_addr, 8'hA5);
        cpu_model_inst.end_addr();
        repeat (6) @(posedge clk);
        check_data(low_addr, 8'hA5);
        $display("t_latch done");
    endtask : t_latch
    task automatic t_ports();
        logic [7:0] r;
        run(1'b1, 8'h00, 8'h01, 1'b1, 8'h2A, r);
        run(1'b1, 8'h00, 8'h02, 1'b1, 8'hC3, r);
        run(1'b1, 8'h00, 8'h12, 1'b1, 8'h96, r);
        check_data({2'b00, pa_out1}, 8'h2A);
        check_data(pa_out0, 8'hC3);
        check_data(pb_out, 8'h96);
        run(1'b1, 8'h00, 8'h00, 1'b0, 8'h00, r);
        check_data(r, 8'h5A);
        run(1'b1, 8'h00, 8'h10, 1'b0, 8'h00, r);
        check_data(r, 8'hE1);
        run(1'b1, 8'h00, 8'h11, 1'b0, 8'h00, r);
        check_data(r, 8'h3C);
        $display("t_ports done");
    endtask : t_ports
    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        rst_n = 1'b0;
        pa_in = 8'h00;
        pb0_in = 8'h00;
        pb1_in = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        pa_in <= 8'h5A;
        pb0_in <= 8'hE1;
        pb1_in <= 8'h3C;
        repeat (6) @(posedge clk);
        check_sel(sel, 7'h7F);
        t_mem();
        t_io();
        t_latch();
        t_ports();
        print_verdict();
    end
    // A bus cycle takes about 24 clocks and the run has under 25 of them; the margin is wide on purpose.
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        print_verdict();
    end
endmodule : test_cpu_bus_address_decode_glue
`default_nettype wire
